// file: smas_pkg.sv
// Package for the signal mast aspect selector: map, fields, reset values, types
package smas_pkg;

  // ************************************************************
  // Sizes
  // ************************************************************
  localparam int RULES_PER_MAST = 8;
  localparam int EV_W = 64;
  localparam int SPD_W = 4;
  localparam int ADDR_W = 16;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam logic [15:0] ADR_IRQ_STAT = 16'h0000;
  localparam logic [15:0] ADR_IRQ_MASK = 16'h0004;
  localparam logic [15:0] ADR_STATE = 16'h0008;
  localparam logic [15:0] ADR_CFG_BASE = 16'h0100;
  localparam logic [15:0] ADR_ACT_BASE = 16'h0180;
  localparam logic [15:0] ADR_LINK_BASE = 16'h0200;
  localparam logic [15:0] ADR_SLOT_BASE = 16'h1000;

  // Word positions inside one rule slot (8 words per slot)
  localparam logic [2:0] W_CONS = 3'h0;
  localparam logic [2:0] W_SET = 3'h2;
  localparam logic [2:0] W_CLR = 3'h4;
  localparam logic [2:0] W_SPEED = 3'h6;
  localparam logic [2:0] W_NAME = 3'h7;

  // ************************************************************
  // Fields and reset values
  // ************************************************************
  localparam logic [1:0] MODE_UNUSED = 2'h0;
  localparam logic [1:0] MODE_NORMAL = 2'h1;
  localparam logic [1:0] MODE_LINKED = 2'h2;
  localparam int IRQ_SET = 0;
  localparam int IRQ_CLR = 1;
  localparam int IRQ_SPD = 2;
  localparam logic [2:0] IRQ_RST = 3'h0;
  localparam logic [31:0] WORD_RST = 32'h0;

  // ************************************************************
  // Types
  // ************************************************************
  typedef struct packed {
    logic fade;
    logic [1:0] mode;
  } smas_cfg_type;

  typedef struct packed {
    logic valid;
    logic [2:0] rule;
  } smas_act_type;

  localparam smas_cfg_type CFG_RST = '{fade: 1'b0, mode: MODE_UNUSED};
  localparam smas_act_type ACT_RST = '{valid: 1'b0, rule: 3'h0};

  typedef enum logic [1:0] {ST_IDLE, ST_CLR, ST_SET, ST_SPD} smas_state_type;

endpackage : smas_pkg

// file: smas_top.sv
// Signal mast aspect selector with APB register file and event ports
// Functional notes
// - An unused mast entry never matches, consumes or produces rule events.
// - A normal mast entry holds eight rule slots with their own events.
// - A linked-to-previous entry joins the entry before it as one mast.
// - Linking chains across any number of successive entries.
// - Selecting a rule deactivates the active rule in every entry of the group.
// - Speed of any rule in a group goes out under the group's first entry.
// - Each mast shows a read-only link address; the group's first entry's address is the base for the group's speed events.
// - A per-mast fade bit picks incandescent fade or immediate change.
// - A slot's consumed event makes that rule the mast's active aspect.
// - A different rule selection clears the active aspect; no clear event consumed.
// - A newly active rule sends its set-notification event.
// - A rule displaced by another sends its clear-notification event.
// - Each slot carries a speed code forwarded when the rule becomes active.
// - Speed codes are plain symbols with no physical meaning.
// - The rule name word is stored for software only.
// - Speed events are link base plus a fixed offset per speed code.
module smas_top
  import smas_pkg::*;
#(
  parameter int N_MAST = 8,
  parameter logic [EV_W-1:0] LINK_BASE = 64'h0000_0000_0001_0000 // Arbitrary value
)(
  // Clock and reset
  input wire logic I_CLK,
  input wire logic I_RST_N,
  // APB slave
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [ADDR_W-1:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  input wire logic [3:0] I_PSTRB,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  // Consumed events
  input wire logic I_EV_VALID,
  input wire logic [EV_W-1:0] I_EV_ID,
  output logic O_EV_READY,
  // Produced events
  output logic O_PEV_VALID,
  output logic [EV_W-1:0] O_PEV_ID,
  input wire logic I_PEV_READY,
  // Lamp fade per mast and interrupt
  output logic [N_MAST-1:0] O_FADE,
  output logic O_IRQ
);

  // ************************************************************
  // Declarations
  // ************************************************************
  localparam int MW = $clog2(N_MAST);
  localparam int SW = MW + 3;
  localparam int SLOTS = N_MAST * RULES_PER_MAST;
  localparam int MEM_WORDS = SLOTS * 8;

  logic [31:0] mem_r [MEM_WORDS];
  smas_cfg_type cfg_r [N_MAST];
  smas_act_type act_r [N_MAST];
  logic [MW-1:0] head [N_MAST];
  logic [SLOTS-1:0] match;
  logic [2:0] stat_r;
  logic [2:0] mask_r;
  smas_state_type state_r;
  smas_state_type state_nxt;
  logic [SW-1:0] sel_r;
  logic [SW-1:0] prev_r;
  logic [MW-1:0] head_r;
  logic [31:0] prdata_r;
  logic pready_r;
  logic pslverr_r;
  logic ev_ready_r;
  logic pev_valid_r;
  logic [EV_W-1:0] pev_id_r;
  logic [EV_W-1:0] pev_id_nxt;
  logic irq_r;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [SW:0] first_hit(input logic [SLOTS-1:0] v);
    logic [SW:0] r;
    r = '0;
    for (int i = SLOTS - 1; i >= 0; i--)
    begin
      if (v[i])
      begin
        r = {1'b1, SW'(i)};
      end
    end
    return r;
  endfunction : first_hit

  function automatic logic [EV_W-1:0] slot_ev(input logic [SW-1:0] s, input logic [2:0] w);
    return {mem_r[{s, w + 3'h1}], mem_r[{s, w}]};
  endfunction : slot_ev

  // Speed codes are opaque symbols: each just picks an offset from the base
  function automatic logic [EV_W-1:0] link_of(input logic [MW-1:0] h);
    return LINK_BASE + EV_W'({h, {SPD_W{1'b0}}});
  endfunction : link_of

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                         input logic [3:0] st);
    logic [31:0] m;
    m = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
    return (old & ~m) | (nw & m);
  endfunction : merge

  // ************************************************************
  // Group structure and matching
  // ************************************************************
  // A linked entry inherits the head of the entry before it, so chains of any length fold
  for (genvar m = 0; m < N_MAST; m++)
  begin : g_head
    if (m == 0)
    begin : g_first
      assign head[m] = '0;
    end
    else
    begin : g_rest
      assign head[m] = (cfg_r[m].mode == MODE_LINKED) ? head[m-1] : MW'(m);
    end
  end

  for (genvar s = 0; s < SLOTS; s++)
  begin : g_slot
    assign match[s] = (cfg_r[s / RULES_PER_MAST].mode != MODE_UNUSED)
                      && (slot_ev(SW'(s), W_CONS) == I_EV_ID);
  end

  wire [SW:0] hit = first_hit(match);
  wire [SW-1:0] hit_slot = hit[SW-1:0];
  wire [MW-1:0] hit_mast = hit_slot[SW-1:3];
  wire [2:0] hit_rule = hit_slot[2:0];

  logic prev_found;
  logic [MW-1:0] prev_mast;
  always_comb
  begin
    prev_found = 1'b0;
    prev_mast = '0;
    for (int m = 0; m < N_MAST; m++)
    begin
      if (act_r[m].valid && head[m] == head[hit_mast])
      begin
        prev_found = 1'b1;
        prev_mast = MW'(m);
      end
    end
  end

  wire [SW-1:0] prev_slot = {prev_mast, act_r[prev_mast].rule};
  // Re-selecting the rule already shown changes nothing and sends nothing
  wire reselect = prev_found && prev_slot == hit_slot;
  wire take = I_EV_VALID && ev_ready_r && hit[SW] && !reselect;
  wire fire = pev_valid_r && I_PEV_READY;

  // ************************************************************
  // Notification sequencer
  // ************************************************************
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ST_IDLE:
      begin
        if (take)
        begin
          state_nxt = prev_found ? ST_CLR : ST_SET;
        end
      end
      ST_CLR:
      begin
        if (fire)
        begin
          state_nxt = ST_SET;
        end
      end
      ST_SET:
      begin
        if (fire)
        begin
          state_nxt = ST_SPD;
        end
      end
      ST_SPD:
      begin
        if (fire)
        begin
          state_nxt = ST_IDLE;
        end
      end
    endcase
  end

  wire [SW-1:0] cur_sel = take ? hit_slot : sel_r;
  wire [SW-1:0] cur_prev = take ? prev_slot : prev_r;
  wire [MW-1:0] cur_head = take ? head[hit_mast] : head_r;
  wire [SPD_W-1:0] cur_spd = mem_r[{cur_sel, W_SPEED}][SPD_W-1:0];

  always_comb
  begin
    unique case (state_nxt)
      ST_CLR: pev_id_nxt = slot_ev(cur_prev, W_CLR);
      ST_SET: pev_id_nxt = slot_ev(cur_sel, W_SET);
      ST_SPD: pev_id_nxt = link_of(cur_head) + EV_W'(cur_spd);
      ST_IDLE: pev_id_nxt = pev_id_r;
    endcase
  end

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      state_r <= ST_IDLE;
      pev_valid_r <= 1'b0;
      pev_id_r <= '0;
      ev_ready_r <= 1'b0;
      sel_r <= '0;
      prev_r <= '0;
      head_r <= '0;
    end
    else
    begin
      state_r <= state_nxt;
      pev_valid_r <= state_nxt != ST_IDLE;
      pev_id_r <= pev_id_nxt;
      // New events wait while notifications of the last selection drain
      ev_ready_r <= state_nxt == ST_IDLE;
      sel_r <= cur_sel;
      prev_r <= cur_prev;
      head_r <= cur_head;
    end
  end

  // Active aspect: the whole group is cleared, then the new rule set
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      for (int m = 0; m < N_MAST; m++)
      begin
        act_r[m] <= ACT_RST;
      end
    end
    else if (take)
    begin
      for (int m = 0; m < N_MAST; m++)
      begin
        if (head[m] == head[hit_mast])
        begin
          act_r[m] <= ACT_RST;
        end
      end
      act_r[hit_mast] <= '{valid: 1'b1, rule: hit_rule};
    end
  end

  // ************************************************************
  // APB decode
  // ************************************************************
  wire [ADDR_W-1:0] a = I_PADDR;
  wire [4:0] ent = a[6:2];
  wire [4:0] lnk = a[7:3];
  wire [9:0] mwd = a[11:2];
  wire in_cfg = a[15:7] == ADR_CFG_BASE[15:7] && 32'(ent) < N_MAST;
  wire in_act = a[15:7] == ADR_ACT_BASE[15:7] && 32'(ent) < N_MAST;
  wire in_lnk = a[15:8] == ADR_LINK_BASE[15:8] && 32'(lnk) < N_MAST;
  wire in_mem = a[15:12] == ADR_SLOT_BASE[15:12] && 32'(mwd) < MEM_WORDS;
  wire is_stat = a == ADR_IRQ_STAT;
  wire is_mask = a == ADR_IRQ_MASK;
  wire is_state = a == ADR_STATE;
  wire mapped = in_cfg || in_act || in_lnk || in_mem || is_stat || is_mask || is_state;
  wire setup = I_PSEL && I_PENABLE && !pready_r;
  wire acc = I_PSEL && I_PENABLE && pready_r;
  wire wr = acc && I_PWRITE;
  wire [MW-1:0] ent_m = ent[MW-1:0];
  wire [MW-1:0] lnk_m = lnk[MW-1:0];
  wire [EV_W-1:0] lnk_v = link_of(lnk_m);
  wire [31:0] rdata =
    is_stat ? 32'(stat_r) :
    is_mask ? 32'(mask_r) :
    is_state ? 32'(state_r != ST_IDLE) :
    in_cfg ? 32'(cfg_r[ent_m]) :
    in_act ? 32'(act_r[ent_m]) :
    in_lnk ? (a[2] ? lnk_v[63:32] : lnk_v[31:0]) :
    in_mem ? mem_r[mwd[SW+2:0]] : 32'h0;

  // One wait state: data is sampled in the first access cycle, answered in the next
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      pready_r <= 1'b0;
      pslverr_r <= 1'b0;
      prdata_r <= '0;
    end
    else
    begin
      pready_r <= setup;
      pslverr_r <= setup && !mapped;
      prdata_r <= setup ? rdata : prdata_r;
    end
  end

  // ************************************************************
  // Configuration and slot storage
  // ************************************************************
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      for (int m = 0; m < N_MAST; m++)
      begin
        cfg_r[m] <= CFG_RST;
      end
    end
    else if (wr && in_cfg)
    begin
      cfg_r[ent_m] <= smas_cfg_type'(3'(merge(32'(cfg_r[ent_m]), I_PWDATA, I_PSTRB)));
    end
  end

  // The name word is only stored and read back
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      for (int i = 0; i < MEM_WORDS; i++)
      begin
        mem_r[i] <= WORD_RST;
      end
    end
    else if (wr && in_mem)
    begin
      mem_r[mwd[SW+2:0]] <= merge(mem_r[mwd[SW+2:0]], I_PWDATA, I_PSTRB);
    end
  end

  // ************************************************************
  // Interrupts
  // ************************************************************
  wire [2:0] ev_set = {fire && state_r == ST_SPD, fire && state_r == ST_CLR,
                       fire && state_r == ST_SET};
  wire [2:0] w1c = (wr && is_stat) ? 3'(merge(32'h0, I_PWDATA, I_PSTRB)) : 3'h0;

  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      stat_r <= IRQ_RST;
      mask_r <= IRQ_RST;
      irq_r <= 1'b0;
    end
    else
    begin
      // A new event wins over a clear in the same cycle
      stat_r <= (stat_r & ~w1c) | ev_set;
      mask_r <= (wr && is_mask) ? 3'(merge(32'(mask_r), I_PWDATA, I_PSTRB)) : mask_r;
      irq_r <= |(stat_r & mask_r);
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  logic [N_MAST-1:0] fade_r;
  always_ff @(posedge I_CLK or negedge I_RST_N)
  begin
    if (!I_RST_N)
    begin
      fade_r <= '0;
    end
    else
    begin
      for (int m = 0; m < N_MAST; m++)
      begin
        fade_r[m] <= cfg_r[m].fade;
      end
    end
  end

  assign O_PRDATA = prdata_r;
  assign O_PREADY = pready_r;
  assign O_PSLVERR = pslverr_r;
  assign O_EV_READY = ev_ready_r;
  assign O_PEV_VALID = pev_valid_r;
  assign O_PEV_ID = pev_id_r;
  assign O_FADE = fade_r;
  assign O_IRQ = irq_r;

  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (!I_RST_N);

  unused_quiet_a: assert property (take |-> cfg_r[hit_mast].mode != MODE_UNUSED)
    else $error("unused mast selected a rule");
  select_sets_a: assert property (take |=> act_r[$past(hit_mast)].valid
    && act_r[$past(hit_mast)].rule == $past(hit_rule))
    else $error("selected rule not active");
  group_cancel_a: assert property (take && prev_found && prev_mast != hit_mast
    |=> !act_r[$past(prev_mast)].valid)
    else $error("linked entry kept its aspect");
  clear_first_a: assert property (take && prev_found |=> state_r == ST_CLR
    && pev_valid_r && pev_id_r == slot_ev(prev_r, W_CLR))
    else $error("clear notification missing");
  set_after_a: assert property (take && !prev_found |=> pev_valid_r
    && pev_id_r == slot_ev(sel_r, W_SET))
    else $error("set notification missing");
  speed_route_a: assert property (state_r == ST_SPD |-> pev_id_r == link_of(head_r)
    + EV_W'(mem_r[{sel_r, W_SPEED}][SPD_W-1:0]))
    else $error("speed event wrong");
  idle_silent_a: assert property (state_r == ST_IDLE |-> !pev_valid_r && !$rose(O_PEV_VALID))
    else $error("event produced while idle");
  apb_answer_a: assert property (setup |=> pready_r ##1 !pready_r)
    else $error("apb answer not one cycle");

endmodule : smas_top

// file: smas_evbus.sv
// Event bus partner: offers consumed events and accepts produced events
module smas_evbus
  import smas_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_rst_n,
  // Consumed event source
  input wire logic i_ev_ready,
  output logic o_ev_valid,
  output logic [EV_W-1:0] o_ev_id,
  // Produced event sink
  input wire logic i_pev_valid,
  input wire logic [EV_W-1:0] i_pev_id,
  output logic o_pev_ready
);
  timeunit 1ns;
  timeprecision 1ps;
  // ************************************************************
  // Sink: slow mode stalls every other cycle
  // ************************************************************
  logic slow = 1'b0;
  logic [EV_W-1:0] got[$];
  always_ff @(posedge i_clk or negedge i_rst_n)
    if (!i_rst_n)
      o_pev_ready <= 1'b0;
    else
      o_pev_ready <= slow ? ~o_pev_ready : 1'b1;
  always @(posedge i_clk)
    if (i_pev_valid === 1'b1 && o_pev_ready === 1'b1)
      got.push_back(i_pev_id);
  // ************************************************************
  // Source
  // ************************************************************
  initial
  begin
    o_ev_valid = 1'b0;
    o_ev_id = '0;
  end
  // Returns once the selector is idle again, so the whole burst is in got
  task send(input logic [EV_W-1:0] id);
    @(posedge i_clk);
    o_ev_valid <= 1'b1;
    o_ev_id <= id;
    for (int i = 0; i < 100; i++)
    begin
      @(posedge i_clk);
      if (i_ev_ready === 1'b1)
        break;
    end
    o_ev_valid <= 1'b0;
    // Released id shows the inverted id, never the last value
    o_ev_id <= ~id;
    repeat (2) @(posedge i_clk);
    for (int i = 0; i < 100; i++)
    begin
      if (i_ev_ready === 1'b1)
        break;
      @(posedge i_clk);
    end
  endtask : send
endmodule : smas_evbus

// file: signal_mast_aspect_selector_tb.sv
// Testbench for the signal mast aspect selector
module signal_mast_aspect_selector_tb
  import smas_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [EV_W-1:0] LB = 64'h0000_00a5_0000_0000; // Arbitrary link base
  localparam int NM = 4;
  logic I_CLK, I_RST_N, I_PSEL, I_PENABLE, I_PWRITE;
  logic [ADDR_W-1:0] I_PADDR;
  logic [31:0] I_PWDATA;
  logic [3:0] I_PSTRB;
  logic [31:0] O_PRDATA;
  logic O_PREADY, O_PSLVERR, ev_valid, ev_ready, pev_valid, pev_ready, O_IRQ;
  logic [EV_W-1:0] ev_id, pev_id;
  logic [NM-1:0] O_FADE;
  int err_count = 0;
  int n_checks = 0;
  smas_top #(.N_MAST(NM), .LINK_BASE(LB)) DUT (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_PSEL(I_PSEL),
    .I_PENABLE(I_PENABLE), .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .I_PSTRB(I_PSTRB),
    .O_PRDATA(O_PRDATA), .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .I_EV_VALID(ev_valid), .I_EV_ID(ev_id),
    .O_EV_READY(ev_ready), .O_PEV_VALID(pev_valid), .O_PEV_ID(pev_id), .I_PEV_READY(pev_ready),
    .O_FADE(O_FADE), .O_IRQ(O_IRQ));
  smas_evbus bus (.i_clk(I_CLK), .i_rst_n(I_RST_N), .i_ev_ready(ev_ready), .o_ev_valid(ev_valid),
    .o_ev_id(ev_id), .i_pev_valid(pev_valid), .i_pev_id(pev_id), .o_pev_ready(pev_ready));
  // ************************************************************
  // Tasks
  // ************************************************************
  task summarize;
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d, input logic [3:0] s,
    output logic [31:0] q, output logic e);
    @(posedge I_CLK);
    I_PSEL <= 1'b1;
    I_PENABLE <= 1'b0;
    I_PWRITE <= w;
    I_PADDR <= a;
    I_PWDATA <= d;
    I_PSTRB <= s;
    @(posedge I_CLK);
    I_PENABLE <= 1'b1;
    for (int i = 0; i < 50; i++)
    begin
      @(posedge I_CLK);
      if (O_PREADY === 1'b1)
        break;
    end
    q = O_PRDATA;
    e = O_PSLVERR;
    I_PSEL <= 1'b0;
    I_PENABLE <= 1'b0;
  endtask : apb
  logic [31:0] q;
  logic e;
  task wr(input logic [15:0] a, input logic [31:0] d, input logic [3:0] s = 4'hf);
    apb(1'b1, a, d, s, q, e);
  endtask : wr
  task rd(input logic [15:0] a);
    apb(1'b0, a, 32'h0, 4'h0, q, e);
  endtask : rd
  task do_reset;
    I_RST_N <= 1'b0;
    repeat (6) @(posedge I_CLK);
    I_RST_N <= 1'b1;
    @(posedge I_CLK);
  endtask : do_reset
  // Kind 1 consumed, 2 set notice, 3 clear notice; upper word nonzero to catch split words
  function automatic logic [63:0] ev(input int k, input int s);
    return {8'(k), 48'h0, 8'(s)};
  endfunction : ev
  function automatic logic [15:0] sa(input int s, input logic [2:0] w);
    return ADR_SLOT_BASE + 16'(s * 32) + 16'(w) * 16'h4;
  endfunction : sa
  task prog(input int s);
    logic [63:0] v;
    for (int k = 0; k < 3; k++)
    begin
      v = ev(k + 1, s);
      wr(sa(s, W_CONS + 3'(2 * k)), v[31:0]);
      wr(sa(s, W_CONS + 3'(2 * k + 1)), v[63:32]);
    end
    wr(sa(s, W_SPEED), 32'(s % 16));
    wr(sa(s, W_NAME), 32'h0000_0bad);
  endtask : prog
  // ************************************************************
  // Stimulus
  // ************************************************************
  initial
  begin
    I_CLK = 1'b0;
    forever #2 I_CLK = ~I_CLK;
  end
  initial
  begin
    repeat (20000) @(posedge I_CLK);
    err_count++;
    summarize;
  end
  int sel[7] = '{0, 1, 9, 17, 17, 24, 99};
  int prg[5] = '{0, 1, 9, 17, 24};
  int act = -1;
  int s;
  logic [63:0] ex[$];
  initial
  begin
    I_RST_N = 1'b0;
    I_PSEL = 1'b0;
    I_PENABLE = 1'b0;
    I_PWRITE = 1'b0;
    I_PADDR = '0;
    I_PWDATA = '0;
    I_PSTRB = 4'h0;
    do_reset;
    chk("pev_count", 64'(bus.got.size()), 64'h0);
    rd(ADR_ACT_BASE);
    chk("act_reset", q, 64'h0);
    rd(16'h0ffc);
    chk("unmapped_err", e, 64'h1);
    chk("unmapped_data", q, 64'h0);
    for (int m = 0; m < NM; m++)
    begin
      wr(ADR_LINK_BASE + 16'(8 * m), 32'h0);
      rd(ADR_LINK_BASE + 16'(8 * m));
      chk("link_lo", q, 64'(32'(LB + 64'(16 * m))));
      rd(ADR_LINK_BASE + 16'(8 * m) + 16'h4);
      chk("link_hi", q, 64'(LB[63:32]));
    end
    wr(ADR_IRQ_MASK, 32'h7, 4'h0);
    rd(ADR_IRQ_MASK);
    chk("mask_strobe", q, 64'h0);
    wr(ADR_CFG_BASE, 32'h5);
    wr(ADR_CFG_BASE + 16'h4, 32'h2);
    wr(ADR_CFG_BASE + 16'h8, 32'h2);
    wr(ADR_CFG_BASE + 16'hc, 32'h0);
    repeat (2) @(posedge I_CLK);
    chk("fade", 64'(O_FADE), 64'h1);
    foreach (prg[i])
      prog(prg[i]);
    rd(sa(0, W_NAME));
    chk("name", q, 64'h0bad);
    // Only byte 0 is enabled, so the upper bytes of the name word survive
    wr(sa(0, W_NAME), 32'h1234_5678, 4'h1);
    rd(sa(0, W_NAME));
    chk("name_strobe", q, 64'h0b78);
    // Masts 0 to 2 form one linked group headed by mast 0; mast 3 is unused
    foreach (sel[i])
    begin
      s = sel[i];
      bus.slow = (i > 1);
      ex.delete();
      if (s < 24 && s != act)
      begin
        if (act >= 0)
          ex.push_back(ev(3, act));
        ex.push_back(ev(2, s));
        ex.push_back(LB + 64'(s % 16));
        act = s;
      end
      bus.send(ev(1, s));
      chk("pev_count", 64'(bus.got.size()), 64'(ex.size()));
      foreach (ex[j])
        chk("pev_id", (bus.got.size() > 0) ? bus.got.pop_front() : 64'hx, ex[j]);
      bus.got.delete();
      for (int m = 0; m < NM; m++)
      begin
        rd(ADR_ACT_BASE + 16'(4 * m));
        chk("act", q, (act >= 0 && act / 8 == m) ? 64'(8 + act % 8) : 64'h0);
      end
    end
    rd(ADR_STATE);
    chk("busy_idle", q, 64'h0);
    rd(ADR_IRQ_STAT);
    chk("irq_stat", q, 64'h7);
    chk("irq_masked", O_IRQ, 64'h0);
    wr(ADR_IRQ_MASK, 32'h7);
    repeat (2) @(posedge I_CLK);
    chk("irq_on", O_IRQ, 64'h1);
    wr(ADR_IRQ_STAT, 32'h7);
    repeat (2) @(posedge I_CLK);
    chk("irq_off", O_IRQ, 64'h0);
    do_reset;
    rd(ADR_ACT_BASE + 16'h8);
    chk("act_rerst", q, 64'h0);
    chk("pev_rerst", 64'(bus.got.size()), 64'h0);
    summarize;
  end
endmodule : signal_mast_aspect_selector_tb
